// ---- logic/sssrc_top.sv ----
// Purpose: start/stop source selection and overload configuration
// Assumes: APB slave on pclk; pins synchronised here
// Notes: thermal state written by the overload model over APB
`timescale 1ns/1ns
`default_nettype none
`include "sssrc_defines.svh"
module sssrc_top (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// command pins: keypad, terminal
	input wire logic keypad_start,
	input wire logic keypad_stop,
	input wire logic term_start,
	input wire logic term_stop,
	// serial network commands, same clock
	input wire logic serial_start,
	input wire logic serial_stop,
	// local/remote selector input pin
	input wire logic lr_pin,
	// motor status
	input wire logic up_to_speed,
	// outputs
	output logic start_cmd,
	output logic stop_cmd,
	output logic remote_active_ff,
	output logic ol_enable_ff,
	output logic [5:0] ol_class_ff,
	output logic ol_tripped_ff,
	output logic irq_ff
);
	import sssrc_pkg::*;
	// synchronisers: keypad start/stop, terminal start/stop, selector
	logic [4:0] sync1_ff;
	logic [4:0] sync2_ff;
	logic [1:0] pri_src_ff;
	logic [1:0] sec_src_ff;
	logic di_sel_ff;
	logic lr_bit_ff;
	sssrc_class_t run_class_ff;
	sssrc_class_t start_class_ff;
	logic sep_ol_ff;
	logic [6:0] therm_ff;
	logic [`SSSRC_IRQ_W-1:0] stat_ff;
	logic [`SSSRC_IRQ_W-1:0] mask_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= 5'h00;
			sync2_ff <= 5'h00;
		end else begin
			sync1_ff <= {lr_pin, term_stop, term_start, keypad_stop, keypad_start};
			sync2_ff <= sync1_ff;
		end
	end
	// apb decode
	wire setup = psel && !penable;
	// writes land on the access edge that sees pready
	wire acc_done = psel && penable && pready_ff;
	wire wr = acc_done && pwrite;
	wire rd = setup && !pwrite;
	wire hit_src = paddr == `SSSRC_OFF_SRC;
	wire hit_ctrl = paddr == `SSSRC_OFF_CTRL;
	wire hit_ol = paddr == `SSSRC_OFF_OL;
	wire hit_therm = paddr == `SSSRC_OFF_THERM;
	wire hit_stat = paddr == `SSSRC_OFF_STAT;
	wire hit_irq = paddr == `SSSRC_OFF_IRQ;
	wire hit_mask = paddr == `SSSRC_OFF_MASK;
	wire mapped = hit_src | hit_ctrl | hit_ol | hit_therm | hit_stat | hit_irq | hit_mask;
	wire [1:0] wr_pri = pwdata[`SSSRC_SRC_PRI_LSB +: 2];
	wire [1:0] wr_sec = pwdata[`SSSRC_SRC_SEC_LSB +: 2];
	wire [6:0] wr_therm = pwdata[6:0];
	// source choice
	wire use_remote = di_sel_ff ? sync2_ff[4] : lr_bit_ff;
	wire [1:0] act_src = use_remote ? sec_src_ff : pri_src_ff;
	wire nxt_tripped = therm_ff == `SSSRC_THERM_MAX;
	// class off (0) removes protection only once up to speed
	wire starting = !up_to_speed;
	wire [5:0] nxt_class = (sep_ol_ff && starting) ? start_class_ff : run_class_ff;
	wire nxt_ol_en = starting || (run_class_ff != 6'h00);
	wire start_fwd;
	wire stop_fwd;
	logic start_d_ff;
	logic stop_d_ff;
	wire [`SSSRC_IRQ_W-1:0] events = {stop_fwd & ~stop_d_ff, start_fwd & ~start_d_ff,
		nxt_tripped & ~ol_tripped_ff};
	wire [`SSSRC_IRQ_W-1:0] stat_clr = (wr && hit_stat) ? pwdata[`SSSRC_IRQ_W-1:0] : '0;
	wire [`SSSRC_IRQ_W-1:0] nxt_stat = events | (stat_ff & ~stat_clr);
	sssrc_cmd_mux u_mux (
		.pclk(pclk),
		.presetn(presetn),
		.src_sel(act_src),
		.start_in({serial_start, sync2_ff[2], sync2_ff[0]}),
		.stop_in({serial_stop, sync2_ff[3], sync2_ff[1]}),
		.start_out(start_fwd),
		.stop_out(stop_fwd)
	);
	// read mux
	logic [31:0] rd_val;
	always_comb begin
		rd_val = 32'h0000_0000;
		if (hit_src) begin
			rd_val = {27'h0, di_sel_ff, sec_src_ff, pri_src_ff};
		end else if (hit_ctrl) begin
			rd_val = {31'h0, lr_bit_ff};
		end else if (hit_ol) begin
			rd_val = {15'h0, sep_ol_ff, 2'h0, start_class_ff, 2'h0, run_class_ff};
		end else if (hit_therm) begin
			rd_val = {25'h0, therm_ff};
		end else if (hit_stat) begin
			rd_val = {29'h0, stat_ff};
		end else if (hit_irq) begin
			rd_val = {26'h0, ol_enable_ff, ol_tripped_ff, remote_active_ff, 1'b0, act_src};
		end else if (hit_mask) begin
			rd_val = {29'h0, mask_ff};
		end
	end
	// configuration writes; illegal source code keeps old value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pri_src_ff <= `SSSRC_RST_SRC;
			sec_src_ff <= `SSSRC_RST_SRC;
			di_sel_ff <= 1'b0;
			lr_bit_ff <= 1'b0;
			run_class_ff <= `SSSRC_RST_CLASS;
			start_class_ff <= `SSSRC_RST_CLASS;
			sep_ol_ff <= 1'b0;
			mask_ff <= '0;
		end else if (wr) begin
			if (hit_src && wr_pri != 2'd3) begin
				pri_src_ff <= wr_pri;
			end
			if (hit_src && wr_sec != 2'd3) begin
				sec_src_ff <= wr_sec;
			end
			if (hit_src) begin
				di_sel_ff <= pwdata[`SSSRC_SRC_DISEL_LSB];
			end
			if (hit_ctrl) begin
				lr_bit_ff <= pwdata[`SSSRC_CTRL_LR_BIT];
			end
			if (hit_ol) begin
				run_class_ff <= pwdata[`SSSRC_OL_RUN_LSB +: 6];
				start_class_ff <= pwdata[`SSSRC_OL_START_LSB +: 6];
				sep_ol_ff <= pwdata[`SSSRC_OL_SEP_BIT];
			end
			if (hit_mask) begin
				mask_ff <= pwdata[`SSSRC_IRQ_W-1:0];
			end
		end
	end
	// thermal state, values above 100 clamp
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			therm_ff <= 7'h00;
		end else if (wr && hit_therm) begin
			therm_ff <= (wr_therm > `SSSRC_THERM_MAX) ? `SSSRC_THERM_MAX : wr_therm;
		end
	end
	// status and outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_ff <= '0;
			irq_ff <= 1'b0;
			remote_active_ff <= 1'b0;
			ol_tripped_ff <= 1'b0;
			ol_enable_ff <= 1'b1;
			ol_class_ff <= `SSSRC_RST_CLASS;
			start_d_ff <= 1'b0;
			stop_d_ff <= 1'b0;
		end else begin
			stat_ff <= nxt_stat;
			irq_ff <= |(nxt_stat & mask_ff);
			remote_active_ff <= use_remote;
			ol_tripped_ff <= nxt_tripped;
			ol_enable_ff <= nxt_ol_en;
			ol_class_ff <= nxt_class;
			start_d_ff <= start_fwd;
			stop_d_ff <= stop_fwd;
		end
	end
	// command outputs one flop behind the mux
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_cmd <= 1'b0;
			stop_cmd <= 1'b0;
		end else begin
			start_cmd <= start_fwd;
			stop_cmd <= stop_fwd;
		end
	end
	// apb answer: no wait states, pready in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff <= setup;
			pslverr_ff <= setup && !mapped;
			prdata_ff <= rd ? rd_val : 32'h0000_0000;
		end
	end
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
endmodule : sssrc_top
`default_nettype wire

// ---- logic/sssrc_defines.svh ----
// Purpose: offsets, fields, reset values of the start/stop source selector
// Assumes: APB, 32-bit words, one aligned word per register
// Notes: included by the top module only
// Overview of operation
// - only one of three sources commands
// - primary source setting resets to terminal
// - selector input low picks primary source
// - selector input high picks secondary source
// - no selector input, serial bit chooses
// - serial selector bit resets to local
// - thermal state held from 0 to 100
// - thermal state 100 means overload tripped
// - class off disables overload once up
// - separate enable gives distinct starting class
`ifndef SSSRC_DEFINES_SVH
`define SSSRC_DEFINES_SVH
`define SSSRC_OFF_SRC 12'h000
`define SSSRC_OFF_CTRL 12'h004
`define SSSRC_OFF_OL 12'h008
`define SSSRC_OFF_THERM 12'h00C
`define SSSRC_OFF_STAT 12'h010
`define SSSRC_OFF_IRQ 12'h014
`define SSSRC_OFF_MASK 12'h018
`define SSSRC_SRC_PRI_LSB 0
`define SSSRC_SRC_SEC_LSB 2
`define SSSRC_SRC_DISEL_LSB 4
`define SSSRC_CTRL_LR_BIT 0
`define SSSRC_OL_RUN_LSB 0
`define SSSRC_OL_START_LSB 8
`define SSSRC_OL_SEP_BIT 16
`define SSSRC_RST_SRC 2'h1
`define SSSRC_RST_CLASS 6'h0A
`define SSSRC_THERM_MAX 7'h64
`define SSSRC_IRQ_W 3
`define SSSRC_IRQ_TRIP 0
`define SSSRC_IRQ_START 1
`define SSSRC_IRQ_STOP 2
`endif

// ---- logic/sssrc_pkg.sv ----
// Purpose: types of the start/stop source selector
// Assumes: defines header present
// Notes: source codes match the setting encoding
package sssrc_pkg;
	typedef enum logic [1:0] {
		SSSRC_KEYPAD = 2'h0,
		SSSRC_TERMINAL = 2'h1,
		SSSRC_SERIAL = 2'h2
	} sssrc_src_e;
	typedef logic [5:0] sssrc_class_t;
endpackage : sssrc_pkg

// ---- logic/sssrc_cmd_mux.sv ----
// Purpose: pick start/stop from the chosen source
// Assumes: inputs synchronous to pclk
// Notes: outputs registered
`timescale 1ns/1ns
`default_nettype none
module sssrc_cmd_mux (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// selection
	input wire logic [1:0] src_sel,
	// start/stop per source: keypad, terminal, serial
	input wire logic [2:0] start_in,
	input wire logic [2:0] stop_in,
	// forwarded commands
	output logic start_out,
	output logic stop_out
);
	import sssrc_pkg::*;
	logic nxt_start;
	logic nxt_stop;
	// others fall out; illegal code forwards nothing
	assign nxt_start = (src_sel < 2'd3) ? start_in[src_sel] : 1'b0;
	assign nxt_stop = (src_sel < 2'd3) ? stop_in[src_sel] : 1'b0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_out <= 1'b0;
			stop_out <= 1'b0;
		end else begin
			start_out <= nxt_start;
			stop_out <= nxt_stop;
		end
	end
endmodule : sssrc_cmd_mux
`default_nettype wire

// ---- verif/sssrc_assertions.sv ----
// Purpose: port checks of sssrc_top
// Assumes: one clock, async reset
// Notes: bound after the module
`timescale 1ns/1ns
`default_nettype none
module sssrc_assertions (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// pins and outputs
	input wire logic keypad_start,
	input wire logic term_start,
	input wire logic serial_start,
	input wire logic lr_pin,
	input wire logic up_to_speed,
	input wire logic start_cmd,
	input wire logic remote_active_ff,
	input wire logic ol_enable_ff,
	input wire logic [5:0] ol_class_ff,
	input wire logic ol_tripped_ff
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	chk_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
	chk_off_when_up: assert property (!ol_enable_ff |-> $past(up_to_speed)) else $error("overload off while starting");
	chk_on_when_starting: assert property (!up_to_speed |=> ol_enable_ff) else $error("overload off in start");
	chk_off_class_zero: assert property (!ol_enable_ff |-> ol_class_ff == 6'h00) else $error("class not off");
	chk_trip_hold: assert property (!psel [*3] |=> $stable(ol_tripped_ff)) else $error("trip moved unwritten");
	chk_remote_hold: assert property ((!psel && $stable(lr_pin)) [*5] |=> $stable(remote_active_ff))
		else $error("remote moved alone");
	chk_start_hold: assert property ((!psel && $stable({keypad_start, term_start, serial_start, lr_pin})) [*6]
		|=> $stable(start_cmd)) else $error("start moved alone");
endmodule : sssrc_assertions
bind sssrc_top sssrc_assertions sssrc_assertions_i (.pclk, .presetn, .psel, .penable, .pready, .keypad_start,
	.term_start, .serial_start, .lr_pin, .up_to_speed, .start_cmd, .remote_active_ff, .ol_enable_ff,
	.ol_class_ff, .ol_tripped_ff);
`default_nettype wire

// ---- verif/sssrc_src_model.sv ----
// Purpose: keypad, terminal and network sources
// Assumes: controls change just after pclk edges
// Notes: only the commanded source shows a command
`timescale 1ns/1ns
`default_nettype none
module sssrc_src_model (
	// control
	input wire logic [1:0] src,
	input wire logic go_start,
	input wire logic go_stop,
	// lines: keypad, terminal, serial
	output logic [2:0] start_o,
	output logic [2:0] stop_o
);
	assign start_o = {2'h0, go_start} << src;
	assign stop_o = {2'h0, go_stop} << src;
endmodule : sssrc_src_model
`default_nettype wire

// ---- verif/sssrc_top_tb_top.sv ----
// Purpose: bench for sssrc_top
// Assumes: APB slave without extra waits
// Notes: commands come from the source model
`timescale 1ns/1ns
`default_nettype none
module sssrc_top_tb_top;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, perr, lr_pin = 1'b0, up = 1'b0, go_s = 1'b0, go_p = 1'b0;
	logic start_cmd, stop_cmd, remote, ol_en, trip, irq;
	logic [5:0] cls;
	logic [1:0] src = 2'h0;
	logic [2:0] st, sp;
	int miscompares = 0, total_checks = 0;
	initial forever #2 pclk = ~pclk;
	sssrc_src_model sssrc_src_model_i (.src, .go_start(go_s), .go_stop(go_p), .start_o(st), .stop_o(sp));
	sssrc_top sssrc_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .keypad_start(st[0]), .keypad_stop(sp[0]), .term_start(st[1]), .term_stop(sp[1]),
		.serial_start(st[2]), .serial_stop(sp[2]), .lr_pin, .up_to_speed(up), .start_cmd, .stop_cmd,
		.remote_active_ff(remote), .ol_enable_ff(ol_en), .ol_class_ff(cls), .ol_tripped_ff(trip), .irq_ff(irq));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask : rchk
	task automatic cmd(input logic [1:0] s, input logic e);
		src <= s;
		go_s <= 1'b1;
		repeat (6) @(posedge pclk);
		chk(start_cmd, e);
		go_s <= 1'b0;
		go_p <= 1'b1;
		repeat (6) @(posedge pclk);
		chk(stop_cmd, e);
		go_p <= 1'b0;
		repeat (6) @(posedge pclk);
	endtask : cmd
	task automatic t_reset;
		rchk(12'h000, 32'h0000_0005);
		rchk(12'h004, 32'h0000_0000);
		rchk(12'h008, 32'h0000_0A0A);
		rchk(12'h01C, 32'h0000_0000);
		chk(perr, 1'b1);
	endtask : t_reset
	task automatic t_pins;
		for (int p = 0; p < 3; p++) begin
			apb(1'b1, 12'h000, 32'h10 | ((p + 1) % 3) << 2 | p);
			for (int l = 0; l < 2; l++) begin
				lr_pin <= l[0];
				for (int s = 0; s < 3; s++) cmd(s[1:0], s == (l ? (p + 1) % 3 : p));
				chk(remote, l[0]);
			end
		end
	endtask : t_pins
	task automatic t_serial;
		apb(1'b1, 12'h000, 32'h0000_0008);
		lr_pin <= 1'b0;
		cmd(2'h0, 1'b1);
		apb(1'b1, 12'h004, 32'h0000_0001);
		cmd(2'h2, 1'b1);
		cmd(2'h0, 1'b0);
		chk(remote, 1'b1);
		rchk(12'h014, 32'h0000_002A);
		apb(1'b1, 12'h000, 32'h0000_001F);
		rchk(12'h000, 32'h0000_0018);
	endtask : t_serial
	task automatic t_ol;
		apb(1'b1, 12'h00C, 32'h0000_0063);
		rchk(12'h00C, 32'h0000_0063);
		chk(trip, 1'b0);
		apb(1'b1, 12'h00C, 32'h0000_007F);
		rchk(12'h00C, 32'h0000_0064);
		chk({trip, irq}, 2'h2);
		apb(1'b1, 12'h018, 32'h0000_0001);
		@(posedge pclk);
		chk(irq, 1'b1);
		apb(1'b1, 12'h010, 32'h0000_0001);
		@(posedge pclk);
		chk(irq, 1'b0);
		rchk(12'h010, 32'h0000_0006);
		rchk(12'h018, 32'h0000_0001);
		apb(1'b1, 12'h008, 32'h0001_0500);
		repeat (2) @(posedge pclk);
		chk({ol_en, cls}, 7'h45);
		up <= 1'b1;
		repeat (2) @(posedge pclk);
		chk({ol_en, cls}, 7'h00);
		apb(1'b1, 12'h008, 32'h0000_0503);
		up <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({ol_en, cls}, 7'h43);
	endtask : t_ol
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_pins();
		t_serial();
		t_ol();
		stop_test();
	end
	initial begin
		#40000;
		miscompares++;
		stop_test();
	end
endmodule : sssrc_top_tb_top
`default_nettype wire
